// ===== inc/dpll_phase_cfg_regs.vh
// register offsets, fields, reset values and timing counts of the phase range and edge window block
`ifndef DPLL_PHASE_CFG_REGS_VH
`define DPLL_PHASE_CFG_REGS_VH

// register offsets
`define COARSE_RANGE_OFFSET 8'h74
`define EDGE_WINDOW_OFFSET 8'h75

// reset values
`define COARSE_RANGE_RESET 8'hE5
`define EDGE_WINDOW_RESET 8'h06

// field positions of the coarse range register
`define PHASE_LOSS_EN_BIT 7
`define WIDE_RANGE_EN_BIT 6
`define MULTICYCLE_USE_BIT 5
`define RANGE_CODE_MSB 3
`define RANGE_CODE_LSB 0

// field position of the edge window register
`define EDGE_GATE_EN_BIT 7

// range code limits
`define RANGE_CODE_SAT 4'hC
`define RANGE_UI_MAX 13'h1FFF

// phase word: one unit interval (360 degrees) in fractional steps
`define PHASE_FRAC_BITS 8

// reference frequency select codes
`define FREQ_SEL_HIGH 2'h0
`define FREQ_SEL_2K 2'h1
`define FREQ_SEL_4K 2'h2
`define FREQ_SEL_8K 2'h3

// clock rate and low-frequency reference rates in hertz
`define REF_CLK_HZ 10000000
`define FREQ_2K_HZ 2000
`define FREQ_4K_HZ 4000
`define FREQ_8K_HZ 8000

// window tolerance in percent of the period
`define WINDOW_PERCENT 5

// periods in clock cycles, derived from the rates
`define PERIOD_2K_CYC (`REF_CLK_HZ / `FREQ_2K_HZ)
`define PERIOD_4K_CYC (`REF_CLK_HZ / `FREQ_4K_HZ)
`define PERIOD_8K_CYC (`REF_CLK_HZ / `FREQ_8K_HZ)

// tolerance in cycles, rounded down so the window never widens
`define TOL_2K_CYC (`PERIOD_2K_CYC * `WINDOW_PERCENT / 100)
`define TOL_4K_CYC (`PERIOD_4K_CYC * `WINDOW_PERCENT / 100)
`define TOL_8K_CYC (`PERIOD_8K_CYC * `WINDOW_PERCENT / 100)

`endif

// ===== hdl/edge_window_gate.v
// edge acceptance window for low-frequency reference inputs
`timescale 1ns/1ps
`default_nettype none
`include "dpll_phase_cfg_regs.vh"

module edge_window_gate (
  input wire ref_clk,
  input wire nrst,
  input wire ref_in,
  input wire gate_en,
  input wire [1:0] freq_sel,
  output reg edge_out,
  output reg edge_rejected
);

  reg sync1_reg;
  reg sync2_reg;
  reg prev_reg;
  reg anchored_reg;
  reg [12:0] cnt_reg;
  wire rise;
  wire low_freq;
  wire [12:0] period;
  wire [12:0] tol;
  wire in_window;
  wire overdue;

  // expected period in cycles for the selected frequency
  function [12:0] period_of;
    input [1:0] sel;
    reg [31:0] full;
    begin
      case (sel)
        `FREQ_SEL_2K: full = `PERIOD_2K_CYC;
        `FREQ_SEL_4K: full = `PERIOD_4K_CYC;
        `FREQ_SEL_8K: full = `PERIOD_8K_CYC;
        default: full = 32'h00000000;
      endcase
      // counts fit in 13 bits, upper bits are always zero
      period_of = full[12:0];
    end
  endfunction

  // tolerance in cycles for the selected frequency
  function [12:0] tol_of;
    input [1:0] sel;
    reg [31:0] full;
    begin
      case (sel)
        `FREQ_SEL_2K: full = `TOL_2K_CYC;
        `FREQ_SEL_4K: full = `TOL_4K_CYC;
        `FREQ_SEL_8K: full = `TOL_8K_CYC;
        default: full = 32'h00000000;
      endcase
      tol_of = full[12:0];
    end
  endfunction

  assign rise = sync2_reg & ~prev_reg;
  assign low_freq = (freq_sel != `FREQ_SEL_HIGH);
  assign period = period_of(freq_sel);
  assign tol = tol_of(freq_sel);
  assign in_window = (cnt_reg >= period - tol) && (cnt_reg <= period + tol);
  assign overdue = (cnt_reg > period + tol);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchroniser and edge detect
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= ref_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // window gating, re-anchors on the first edge after a lost period
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      anchored_reg <= 1'b0;
      cnt_reg <= 13'h0000;
      edge_out <= 1'b0;
      edge_rejected <= 1'b0;
    end else begin
      edge_out <= 1'b0;
      edge_rejected <= 1'b0;
      if (cnt_reg != 13'h1FFF) begin
        cnt_reg <= cnt_reg + 13'h0001;
      end
      if (!gate_en || !low_freq) begin
        anchored_reg <= 1'b0;
        if (rise) begin
          edge_out <= 1'b1;
          cnt_reg <= 13'h0000;
        end
      end else if (rise && (!anchored_reg || in_window)) begin
        edge_out <= 1'b1;
        anchored_reg <= 1'b1;
        cnt_reg <= 13'h0000;
      end else begin
        if (rise) begin
          edge_rejected <= 1'b1;
        end
        if (overdue) begin
          anchored_reg <= 1'b0;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ===== hdl/dpll_phase_range_noise_cfg.v
// phase detector range and input edge window configuration with their detectors
`timescale 1ns/1ps
`default_nettype none
`include "dpll_phase_cfg_regs.vh"

module dpll_phase_range_noise_cfg (
  input wire ref_clk,
  input wire nrst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  output reg [7:0] reg_rdata,
  input wire signed [21:0] phase_err,
  input wire ref_in,
  input wire [1:0] freq_sel,
  output reg phase_loss,
  output reg signed [21:0] dpll_phase,
  output reg [12:0] coarse_track_ui,
  output reg wide_range_active,
  output wire ref_edge,
  output wire ref_edge_rejected
);

  reg [7:0] coarse_range_cfg_reg;
  reg [7:0] input_edge_window_cfg_reg;
  reg [7:0] rdata_next;
  wire [12:0] range_ui;
  wire [12:0] eff_range_ui;
  wire signed [21:0] limit_pos;
  wire signed [21:0] limit_neg;
  wire [21:0] err_mag;
  wire phase_loss_en;
  wire wide_range_en;
  wire multicycle_phase_use;
  wire edge_gate_enable;

  // range in whole unit intervals for a 4-bit code
  function [12:0] range_of_code;
    input [3:0] code;
    begin
      if (code >= `RANGE_CODE_SAT) begin
        range_of_code = `RANGE_UI_MAX;
      end else begin
        range_of_code = (13'h0002 << code) - 13'h0001;
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // register fields
  assign phase_loss_en = coarse_range_cfg_reg[`PHASE_LOSS_EN_BIT];
  assign wide_range_en = coarse_range_cfg_reg[`WIDE_RANGE_EN_BIT];
  assign multicycle_phase_use = coarse_range_cfg_reg[`MULTICYCLE_USE_BIT];
  assign edge_gate_enable = input_edge_window_cfg_reg[`EDGE_GATE_EN_BIT];

  // decoded range and the range the coarse detector really uses
  assign range_ui = range_of_code(coarse_range_cfg_reg[`RANGE_CODE_MSB:`RANGE_CODE_LSB]);
  assign eff_range_ui = wide_range_en ? range_ui : 13'h0001;

  // clamp limits in fractional phase steps
  assign limit_pos = (multicycle_phase_use && wide_range_en) ?
                     $signed({1'b0, eff_range_ui, 8'h00}) : $signed(22'h000100);
  assign limit_neg = -limit_pos;
  assign err_mag = phase_err[21] ? (22'h000000 - phase_err) : phase_err;

  //////////////////////////////////////////////////////////////////////////////
  // register writes
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      coarse_range_cfg_reg <= `COARSE_RANGE_RESET;
      input_edge_window_cfg_reg <= `EDGE_WINDOW_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `COARSE_RANGE_OFFSET) begin
        coarse_range_cfg_reg <= reg_wdata;
      end
      if (reg_addr == `EDGE_WINDOW_OFFSET) begin
        input_edge_window_cfg_reg <= reg_wdata;
      end
    end
  end

  // read data selection, unmapped reads as zero
  always @* begin
    case (reg_addr)
      `COARSE_RANGE_OFFSET: rdata_next = coarse_range_cfg_reg;
      `EDGE_WINDOW_OFFSET: rdata_next = input_edge_window_cfg_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data and detector outputs, all registered
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
      phase_loss <= 1'b0;
      dpll_phase <= 22'sh000000;
      coarse_track_ui <= 13'h0001;
      wide_range_active <= 1'b0;
    end else begin
      reg_rdata <= rdata_next;
      // phase loss above the configured coarse range
      phase_loss <= phase_loss_en && (err_mag > {1'b0, range_ui, 8'h00});
      // span followed by the coarse multi-cycle detector
      coarse_track_ui <= eff_range_ui;
      wide_range_active <= wide_range_en;
      // phase result handed to the loop
      if (phase_err > limit_pos) begin
        dpll_phase <= limit_pos;
      end else if (phase_err < limit_neg) begin
        dpll_phase <= limit_neg;
      end else begin
        dpll_phase <= phase_err;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // low-frequency edge window on the reference input
  edge_window_gate u_gate (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ref_in(ref_in),
    .gate_en(edge_gate_enable),
    .freq_sel(freq_sel),
    .edge_out(ref_edge),
    .edge_rejected(ref_edge_rejected)
  );

endmodule

`default_nettype wire

// ===== tb/dpll_cfg_chk.sv
// assertion checker of the phase config block
`timescale 1ns/1ps
`default_nettype none
module dpll_cfg_chk (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic signed [21:0] phase_err,
  input wire logic [1:0] freq_sel,
  input wire logic phase_loss,
  input wire logic signed [21:0] dpll_phase,
  input wire logic [12:0] coarse_track_ui,
  input wire logic wide_range_active,
  input wire logic ref_edge_rejected
);
  logic gate_reg;
  wire w74 = reg_wr && reg_addr == 8'h74;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ////////////////////
  // copy of the edge gate bit
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) gate_reg <= 1'b0;
    else if (reg_wr && reg_addr == 8'h75) gate_reg <= reg_wdata[7];
  end
  a_wide_bit: assert property (w74 |-> ##2 wide_range_active == $past(reg_wdata[6], 2))
    else $error("wide flag wrong");
  a_loss_off: assert property (w74 && !reg_wdata[7] |-> ##2 !phase_loss)
    else $error("loss while disabled");
  a_loss_cause: assert property (phase_loss |-> $past(phase_err) > 22'sh100 || $past(phase_err) < -22'sh100)
    else $error("loss without error");
  a_clamp_pass: assert property ($past(nrst) && $past(phase_err) <= 22'sh100 && $past(phase_err) >= -22'sh100
    |-> dpll_phase == $past(phase_err))
    else $error("small error altered");
  a_clamp_unit: assert property (!wide_range_active |-> dpll_phase <= 22'sh100 && dpll_phase >= -22'sh100)
    else $error("clamp above one unit");
  a_track_unit: assert property (!wide_range_active |-> coarse_track_ui == 13'h1)
    else $error("span without wide bit");
  a_gate_off: assert property ((!gate_reg) [*5] |-> !ref_edge_rejected)
    else $error("reject with gate off");
  a_high_rate: assert property ((freq_sel == 2'h0) [*5] |-> !ref_edge_rejected)
    else $error("high rate edge rejected");
  c_loss: cover property (phase_loss);
  c_reject: cover property (ref_edge_rejected);
  c_wide: cover property (wide_range_active && phase_loss);
endmodule
bind dpll_phase_range_noise_cfg dpll_cfg_chk i_chk (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .phase_err(phase_err), .freq_sel(freq_sel), .phase_loss(phase_loss),
  .dpll_phase(dpll_phase), .coarse_track_ui(coarse_track_ui), .wide_range_active(wide_range_active),
  .ref_edge_rejected(ref_edge_rejected));
`default_nettype wire

// ===== tb/dpll_phase_range_noise_cfg_tb_top.sv
// self-checking bench of the phase config block
`timescale 1ns/1ps
`default_nettype none
module dpll_phase_range_noise_cfg_tb_top;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic signed [21:0] phase_err = 22'h0;
  logic ref_in = 1'b0;
  logic [1:0] freq_sel = 2'h0;
  logic [7:0] reg_rdata;
  logic phase_loss;
  logic signed [21:0] dpll_phase;
  logic [12:0] coarse_track_ui;
  logic wide_range_active;
  logic ref_edge;
  logic ref_edge_rejected;
  logic [35:0] exp_q[$];
  logic [35:0] ent;
  logic [31:0] obs;
  integer seed = 32'hCD4C;
  integer n_mismatch = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  integer r;
  integer p;
  dpll_phase_range_noise_cfg i_dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .phase_err(phase_err), .ref_in(ref_in), .freq_sel(freq_sel),
    .phase_loss(phase_loss), .dpll_phase(dpll_phase), .coarse_track_ui(coarse_track_ui),
    .wide_range_active(wide_range_active), .ref_edge(ref_edge), .ref_edge_rejected(ref_edge_rejected));
  always #50 ref_clk = ~ref_clk;
  task automatic report_and_stop;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // cycle ceiling against a hang
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      n_mismatch = n_mismatch + 1;
      report_and_stop;
    end
  end
  // settled outputs against noted results
  always @(negedge ref_clk) begin
    while (exp_q.size() > 0) begin
      ent = exp_q.pop_front();
      case (ent[35:32])
        4'h0: obs = {24'h0, reg_rdata};
        4'h1: obs = {31'h0, phase_loss};
        4'h2: obs = {10'h0, dpll_phase};
        4'h3: obs = {19'h0, coarse_track_ui};
        4'h4: obs = {31'h0, wide_range_active};
        default: obs = {30'h0, ref_edge_rejected, ref_edge};
      endcase
      cmp_count = cmp_count + 1;
      if (obs !== ent[31:0]) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch t=%0t exp=%h got=%h", $time, ent[31:0], obs);
      end
    end
  end
  ////////////////////
  task automatic chk(input logic [3:0] s, input logic [31:0] e);
    exp_q.push_back({s, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    @(posedge ref_clk);
    chk(4'h0, {24'h0, e});
  endtask
  task automatic ph(input logic [21:0] v, input logic l, input logic [21:0] d);
    phase_err <= v;
    @(posedge ref_clk);
    chk(4'h1, {31'h0, l});
    chk(4'h2, {10'h0, d});
  endtask
  // rising reference edge after g idle cycles, pulse three edges on
  task automatic ed(input integer g, input logic a);
    repeat (g) @(posedge ref_clk);
    ref_in <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(4'h5, {30'h0, !a, a});
    ref_in <= 1'b0;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    rd(8'h74, 8'hE5);
    rd(8'h75, 8'h06);
    rd(8'h76, 8'h00);
    chk(4'h3, 32'h3F);
    freq_sel <= 2'h3;
    ed(20, 1'b1);
    p = $random(seed);
    wr(8'h74, p[7:0]);
    rd(8'h74, p[7:0]);
    wr(8'h75, p[15:8]);
    rd(8'h75, p[15:8]);
    for (r = 0; r < 16; r = r + 1) begin
      p = (r > 11) ? 8191 : (1 << (r + 1)) - 1;
      wr(8'h74, 8'hE0 | r[7:0]);
      chk(4'h3, p);
      chk(4'h4, 32'h1);
      ph(22'(p * 256 + 1), 1'b1, 22'(p * 256));
      ph(22'(-p * 256), 1'b0, 22'(-p * 256));
    end
    wr(8'h74, 8'h05);
    chk(4'h3, 32'h1);
    chk(4'h4, 32'h0);
    ph(22'h020000, 1'b0, 22'h000100);
    wr(8'h74, 8'hA5);
    ph(22'h3E0000, 1'b1, 22'h3FFF00);
    for (r = 0; r < 8; r = r + 1) begin
      p = $random(seed) % 256;
      ph(22'(p), 1'b0, 22'(p));
    end
    wr(8'h75, 8'h7F);
    ed(20, 1'b1);
    ed(20, 1'b1);
    wr(8'h75, 8'h80);
    freq_sel <= 2'h0;
    ed(20, 1'b1);
    ed(20, 1'b1);
    for (r = 1; r < 4; r = r + 1) begin
      freq_sel <= r[1:0];
      p = 5000 >> (r - 1);
      ed(p + p / 20 + 20, 1'b1);
      ed(p / 3, 1'b0);
      ed(p - p / 3 - 8, 1'b1);
    end
    repeat (2) @(posedge ref_clk);
    report_and_stop;
  end
endmodule
`default_nettype wire
